// ---- cpm_pin_mux.sv ----
// output function selector for six configurable control pins
// What this block does
// - tristate option releases pad; drive options hold a constant level
// - power enable goes low once configured, high again in suspend
// - sleep indicator is low in suspend, high otherwise
// - fast, mid and slow clock outputs run, and stop in suspend
// - gpio is offered on pins 0 to 3 only, each independently
// - charger flag drives high when a dedicated charger is detected
// - inverted charger flag is open drain, pulls low on charger
// - write strobe option passes the active-low bit-bang write strobe
// - read strobe option passes the active-low bit-bang read strobe
// - transmit-empty option drives the active-low transmit buffer flag
// - receive-full option drives the active-low receive buffer flag
// - vbus sense pin is an input that reports vbus presence
// - timestamp pin toggles on every start-of-frame
// - keep-awake pin held low blocks suspend while unplugged
// - every non-gpio option is available on all six pins
// - pin functions come from nonvolatile configuration memory
// - input pins pull up, or optionally pull down during suspend
`timescale 1ns/1ps
module cpm_pin_mux
  import cpm_pkg::*;
(
  input  wire logic                          clk_in,
  input  wire logic                          rstn_in,
  input  wire logic [CPM_PINS*CPM_SEL_W-1:0] nvm_pin_sel_in,
  input  wire logic                          nvm_suspend_pd_in,
  input  wire logic                          usb_configured_in,
  input  wire logic                          usb_suspend_in,
  input  wire logic                          charger_detect_in,
  input  wire logic                          bitbang_write_strobe_n_in,
  input  wire logic                          bitbang_read_strobe_n_in,
  input  wire logic                          tx_buffer_empty_n_in,
  input  wire logic                          rx_buffer_full_n_in,
  input  wire logic                          sof_pulse_in,
  input  wire logic [CPM_GPIO_PINS-1:0]      gpio_data_in,
  input  wire logic [CPM_GPIO_PINS-1:0]      gpio_dir_in,
  input  wire logic [CPM_PINS-1:0]           cfg_pin_in,
  output logic      [CPM_PINS-1:0]           cfg_pin_out,
  output logic      [CPM_PINS-1:0]           cfg_pin_oe_n_out,
  output logic      [CPM_PINS-1:0]           pull_up_en_out,
  output logic      [CPM_PINS-1:0]           pull_down_en_out,
  output logic      [CPM_GPIO_PINS-1:0]      gpio_sample_out,
  output logic                               vbus_present_out,
  output logic                               suspend_inhibit_out,
  output logic                               power_enable_n_out,
  output logic                               sleep_n_out
);

  // suspend state and status flops
  logic susp_q;
  logic power_enable_n_n_q;
  logic power_enable_n_n_d;
  logic sleep_n_q;
  logic tstamp_q;
  logic clk_out_fast;
  logic clk_out_mid;
  logic clk_out_slow;

  logic [CPM_PINS-1:0]      pad_s;
  logic [CPM_PINS-1:0]      is_vbus;
  logic [CPM_PINS-1:0]      is_keep;
  logic [CPM_PINS-1:0]      in_mode;
  logic [CPM_PINS-1:0]      drv_out;
  logic [CPM_PINS-1:0]      drv_oe_n;
  cpm_func_t                fn_w [CPM_PINS];

  // power enable: low once configured, high on suspend
  assign power_enable_n_n_d = usb_suspend_in    ? 1'b1 :
                     usb_configured_in ? 1'b0 : power_enable_n_n_q;

  // suspend sampled into susp_q for clocks and pulls; power enable and sleep sample usb_suspend_in directly
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      susp_q    <= 1'b0;
      power_enable_n_n_q <= CPM_POWER_ENABLE_N_N_RST;
      sleep_n_q <= CPM_SLEEP_N_RST;
    end else begin
      susp_q    <= usb_suspend_in;
      power_enable_n_n_q <= power_enable_n_n_d;
      sleep_n_q <= !usb_suspend_in;
    end
  end

  // timestamp toggles per start-of-frame
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tstamp_q <= CPM_TSTAMP_RST;
    end else if (sof_pulse_in) begin
      tstamp_q <= !tstamp_q;
    end
  end

  // clock outputs, gated by suspend on the low phase
  cpm_clk_div #(.HALF(CPM_FAST_HALF)) u_div_fast (
    .clk_in  (clk_in),
    .rstn_in (rstn_in),
    .run_in  (!susp_q),
    .clk_out (clk_out_fast)
  );
  cpm_clk_div #(.HALF(CPM_MID_HALF)) u_div_mid (
    .clk_in  (clk_in),
    .rstn_in (rstn_in),
    .run_in  (!susp_q),
    .clk_out (clk_out_mid)
  );
  cpm_clk_div #(.HALF(CPM_SLOW_HALF)) u_div_slow (
    .clk_in  (clk_in),
    .rstn_in (rstn_in),
    .run_in  (!susp_q),
    .clk_out (clk_out_slow)
  );

  // pad inputs cross into clk_in before any use
  cpm_sync #(.W(CPM_PINS)) u_pad_sync (
    .clk_in  (clk_in),
    .rstn_in (rstn_in),
    .d_in    (cfg_pin_in),
    .q_out   (pad_s)
  );

  // source levels go in as an argument so the mux follows every change
  logic [10:0] src_lvl;
  assign src_lvl = {tstamp_q, rx_buffer_full_n_in, tx_buffer_empty_n_in,
                    bitbang_read_strobe_n_in, bitbang_write_strobe_n_in,
                    charger_detect_in, clk_out_slow, clk_out_mid,
                    clk_out_fast, sleep_n_q, power_enable_n_n_q};

  // per-pin selection: {oe_n, level}
  function automatic logic [1:0] drive_sel(input cpm_func_t   fn,
                                           input logic [10:0] src,
                                           input logic        gpio_o,
                                           input logic        gpio_dir);
    logic [1:0] r;
    r = 2'b10;
    case (fn)
      CPM_FN_TRISTATE:  r = 2'b10;
      CPM_FN_DRIVE1:    r = 2'b01;
      CPM_FN_DRIVE0:    r = 2'b00;
      CPM_FN_POWER_ENABLE_N:     r = {1'b0, src[0]};
      CPM_FN_SLEEP:     r = {1'b0, src[1]};
      CPM_FN_CLK_FAST:  r = {1'b0, src[2]};
      CPM_FN_CLK_MID:   r = {1'b0, src[3]};
      CPM_FN_CLK_SLOW:  r = {1'b0, src[4]};
      CPM_FN_GPIO:      r = {!gpio_dir, gpio_o};
      CPM_FN_CHARGER:   r = {1'b0, src[5]};
      CPM_FN_CHARGER_N: r = {!src[5], 1'b0};
      CPM_FN_WR_STROBE: r = {1'b0, src[6]};
      CPM_FN_RD_STROBE: r = {1'b0, src[7]};
      CPM_FN_TX_EMPTY:  r = {1'b0, src[8]};
      CPM_FN_RX_FULL:   r = {1'b0, src[9]};
      CPM_FN_TSTAMP:    r = {1'b0, src[10]};
      default:          r = 2'b10;
    endcase
    return r;
  endfunction : drive_sel

  genvar gi;
  generate
    for (gi = 0; gi < CPM_PINS; gi++) begin : g_pin
      logic gpio_o;
      logic gpio_dir;
      logic gpio_in;

      // selector straight from configuration memory
      assign fn_w[gi] = cpm_decode(
        nvm_pin_sel_in[gi*CPM_SEL_W +: CPM_SEL_W], gi);
      if (gi < CPM_GPIO_PINS) begin : g_gpio
        assign gpio_o   = gpio_data_in[gi];
        assign gpio_dir = gpio_dir_in[gi];
        assign gpio_in  = (fn_w[gi] == CPM_FN_GPIO) && !gpio_dir;
      end else begin : g_nogpio
        assign gpio_o   = 1'b0;
        assign gpio_dir = 1'b0;
        assign gpio_in  = 1'b0;
      end
      // same menu on every pin except gpio, refused on pins 4 and 5
      assign {drv_oe_n[gi], drv_out[gi]} =
        drive_sel(fn_w[gi], src_lvl, gpio_o, gpio_dir);
      assign is_vbus[gi] = (fn_w[gi] == CPM_FN_VBUS);
      assign is_keep[gi] = (fn_w[gi] == CPM_FN_KEEP_AWAKE);
      assign in_mode[gi] = is_vbus[gi] || is_keep[gi] || gpio_in;
    end
  endgenerate

  // pad drivers, pulls and input reports come from flops
  wire pd_now = susp_q && nvm_suspend_pd_in;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cfg_pin_out         <= '0;
      cfg_pin_oe_n_out    <= '1;
      pull_up_en_out      <= '0;
      pull_down_en_out    <= '0;
      gpio_sample_out     <= '0;
      vbus_present_out    <= 1'b0;
      suspend_inhibit_out <= 1'b0;
    end else begin
      cfg_pin_out         <= drv_out;
      cfg_pin_oe_n_out    <= drv_oe_n;
      pull_up_en_out      <= in_mode & {CPM_PINS{!pd_now}};
      pull_down_en_out    <= in_mode & {CPM_PINS{pd_now}};
      gpio_sample_out     <= pad_s[CPM_GPIO_PINS-1:0];
      vbus_present_out    <= |(is_vbus & pad_s);
      suspend_inhibit_out <= |(is_keep & ~pad_s);
    end
  end

  assign power_enable_n_out = power_enable_n_n_q;
  assign sleep_n_out        = sleep_n_q;

  // checks on the pin-0 path, the pin-4 gpio refusal and the shared status logic
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  chk_tristate_pad: assert property (
    (fn_w[0] == CPM_FN_TRISTATE) |=> cfg_pin_oe_n_out[0])
    else $error("tristate pin is driven");
  chk_drive_const: assert property (
    (fn_w[0] == CPM_FN_DRIVE1) [*2] |->
      (cfg_pin_out[0] && !cfg_pin_oe_n_out[0]))
    else $error("drive-one pin not high");
  chk_power_enable_n_follow: assert property (
    (usb_configured_in && !usb_suspend_in) |=> !power_enable_n_out)
    else $error("power enable did not go low");
  chk_power_enable_n_hold: assert property (
    (!usb_configured_in && !usb_suspend_in) |=> $stable(power_enable_n_out))
    else $error("power enable moved without cause");
  chk_power_enable_n_suspend: assert property (
    usb_suspend_in |=> power_enable_n_out [*1] ##0 !sleep_n_out)
    else $error("power enable or sleep wrong in suspend");
  chk_sleep_awake: assert property (
    !usb_suspend_in |=> sleep_n_out)
    else $error("sleep indicator low while awake");
  chk_clock_stop: assert property (
    susp_q [*8] |-> !clk_out_fast && !clk_out_mid && !clk_out_slow)
    else $error("clock output running in suspend");
  chk_gpio_range: assert property (
    (nvm_pin_sel_in[4*CPM_SEL_W +: CPM_SEL_W] == CPM_FN_GPIO)
      |=> cfg_pin_oe_n_out[4])
    else $error("gpio accepted on pin 4");
  chk_charger_od: assert property (
    (fn_w[0] == CPM_FN_CHARGER_N) |=>
      !cfg_pin_out[0] && (cfg_pin_oe_n_out[0] == !$past(charger_detect_in)))
    else $error("inverted charger flag not open drain");
  chk_write_strobe: assert property (
    (fn_w[0] == CPM_FN_WR_STROBE) |=> !cfg_pin_oe_n_out[0] &&
      (cfg_pin_out[0] == $past(bitbang_write_strobe_n_in)))
    else $error("write strobe not passed");
  chk_tstamp_toggle: assert property (
    sof_pulse_in |=> (tstamp_q != $past(tstamp_q)))
    else $error("timestamp did not toggle");
  chk_tstamp_hold: assert property (
    !sof_pulse_in |=> $stable(tstamp_q))
    else $error("timestamp changed without frame");
  chk_keep_awake: assert property (
    (|(is_keep & ~pad_s)) |=> suspend_inhibit_out)
    else $error("keep-awake not reported");
  chk_suspend_pull: assert property (
    (in_mode[0] && susp_q && nvm_suspend_pd_in) |=>
      pull_down_en_out[0] && !pull_up_en_out[0])
    else $error("suspend pull-down not applied");
  chk_pull_awake: assert property (
    (in_mode[0] && !susp_q) |=> pull_up_en_out[0] && !pull_down_en_out[0])
    else $error("input pin not pulled up");

  // constant, gpio and pass-through checks on other pins and sources
  chk_drive_zero: assert property (
    (fn_w[1] == CPM_FN_DRIVE0) [*2] |->
      (!cfg_pin_out[1] && !cfg_pin_oe_n_out[1]))
    else $error("drive-zero pin not low");
  chk_gpio_drive: assert property (
    (fn_w[3] == CPM_FN_GPIO && gpio_dir_in[3]) |=> !cfg_pin_oe_n_out[3] &&
      (cfg_pin_out[3] == $past(gpio_data_in[3])))
    else $error("gpio output not driven");
  chk_charger_flag: assert property (
    (fn_w[0] == CPM_FN_CHARGER) |=> !cfg_pin_oe_n_out[0] &&
      (cfg_pin_out[0] == $past(charger_detect_in)))
    else $error("charger flag not passed");
  chk_read_strobe: assert property (
    (fn_w[0] == CPM_FN_RD_STROBE) |=> !cfg_pin_oe_n_out[0] &&
      (cfg_pin_out[0] == $past(bitbang_read_strobe_n_in)))
    else $error("read strobe not passed");
  chk_tx_empty: assert property (
    (fn_w[0] == CPM_FN_TX_EMPTY) |=> !cfg_pin_oe_n_out[0] &&
      (cfg_pin_out[0] == $past(tx_buffer_empty_n_in)))
    else $error("transmit-empty flag not passed");
  chk_rx_full: assert property (
    (fn_w[0] == CPM_FN_RX_FULL) |=> !cfg_pin_oe_n_out[0] &&
      (cfg_pin_out[0] == $past(rx_buffer_full_n_in)))
    else $error("receive-full flag not passed");

  // vbus sense pins stay released and report the pad level
  chk_vbus_released: assert property (
    (|is_vbus) |=>
      ((cfg_pin_oe_n_out & $past(is_vbus)) == $past(is_vbus)))
    else $error("vbus sense pin is driven");
  chk_vbus_report: assert property (
    (|(is_vbus & pad_s)) |=> vbus_present_out)
    else $error("vbus presence not reported");

  cov_config_then_suspend: cover property (
    !power_enable_n_out ##[1:20] power_enable_n_out);
  cov_frame_toggle: cover property (sof_pulse_in ##1 sof_pulse_in);
  cov_clock_restart: cover property (susp_q ##1 !susp_q ##[1:8] clk_out_slow);
  cov_vbus_seen: cover property ($rose(vbus_present_out));
  cov_gpio_drive: cover property (
    fn_w[3] == CPM_FN_GPIO && !cfg_pin_oe_n_out[3]);

endmodule : cpm_pin_mux

// ---- cpm_pkg.sv ----
// shared constants and types for the configurable pin function mux
package cpm_pkg;

  // pin counts and selector width
  localparam int CPM_PINS      = 6;
  localparam int CPM_GPIO_PINS = 4;
  localparam int CPM_SEL_W     = 5;

  // clock rates in Hz
  localparam int CPM_CLK_HZ  = 40_000_000;
  localparam int CPM_FAST_HZ = 24_000_000;
  localparam int CPM_MID_HZ  = 12_000_000;
  localparam int CPM_SLOW_HZ = 6_000_000;

  // half periods in clk_in cycles, rounded down, never below one
  localparam int CPM_FAST_HALF_RAW = CPM_CLK_HZ / (2 * CPM_FAST_HZ);
  localparam int CPM_MID_HALF_RAW  = CPM_CLK_HZ / (2 * CPM_MID_HZ);
  localparam int CPM_SLOW_HALF_RAW = CPM_CLK_HZ / (2 * CPM_SLOW_HZ);
  localparam int CPM_FAST_HALF = (CPM_FAST_HALF_RAW < 1) ? 1 : CPM_FAST_HALF_RAW;
  localparam int CPM_MID_HALF  = (CPM_MID_HALF_RAW < 1) ? 1 : CPM_MID_HALF_RAW;
  localparam int CPM_SLOW_HALF = (CPM_SLOW_HALF_RAW < 1) ? 1 : CPM_SLOW_HALF_RAW;
  localparam int CPM_HALF_W    = 8;

  // reset values of the status outputs
  localparam logic CPM_POWER_ENABLE_N_N_RST = 1'b1;
  localparam logic CPM_SLEEP_N_RST = 1'b1;
  localparam logic CPM_TSTAMP_RST  = 1'b0;

  // pin function selector codes
  typedef enum logic [CPM_SEL_W-1:0] {
    CPM_FN_TRISTATE  = 5'h00,
    CPM_FN_DRIVE1    = 5'h01,
    CPM_FN_DRIVE0    = 5'h02,
    CPM_FN_POWER_ENABLE_N     = 5'h03,
    CPM_FN_SLEEP     = 5'h04,
    CPM_FN_CLK_FAST  = 5'h05,
    CPM_FN_CLK_MID   = 5'h06,
    CPM_FN_CLK_SLOW  = 5'h07,
    CPM_FN_GPIO      = 5'h08,
    CPM_FN_CHARGER   = 5'h09,
    CPM_FN_CHARGER_N = 5'h0a,
    CPM_FN_WR_STROBE = 5'h0b,
    CPM_FN_RD_STROBE = 5'h0c,
    CPM_FN_TX_EMPTY  = 5'h0d,
    CPM_FN_RX_FULL   = 5'h0e,
    CPM_FN_VBUS      = 5'h0f,
    CPM_FN_TSTAMP    = 5'h10,
    CPM_FN_KEEP_AWAKE = 5'h11
  } cpm_func_t;

  // raw selector to function; unused codes and gpio above pin 3 release
  function automatic cpm_func_t cpm_decode(input logic [CPM_SEL_W-1:0] code,
                                           input int pin);
    cpm_func_t fn;
    fn = CPM_FN_TRISTATE;
    if (code <= 5'h11) begin
      fn = cpm_func_t'(code);
    end
    if (fn == CPM_FN_GPIO && pin >= CPM_GPIO_PINS) begin
      fn = CPM_FN_TRISTATE;
    end
    return fn;
  endfunction : cpm_decode

endpackage : cpm_pkg

// ---- cpm_sync.sv ----
// two flip-flop synchroniser for pad inputs
`timescale 1ns/1ps
module cpm_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         rstn_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_q;

  // first stage only feeds the second
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_q <= '0;
      q_out  <= '0;
    end else begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end
endmodule : cpm_sync

// ---- cpm_clk_div.sv ----
// divided clock with clean stop and start on the low phase
`timescale 1ns/1ps
module cpm_clk_div
  import cpm_pkg::*;
#(
  parameter int HALF = 1
) (
  input  wire logic clk_in,
  input  wire logic rstn_in,
  input  wire logic run_in,
  output logic      clk_out
);
  localparam logic [CPM_HALF_W-1:0] LAST = CPM_HALF_W'(HALF - 1);

  logic [CPM_HALF_W-1:0] cnt_q;
  wire                   hold_low = !clk_out && !run_in;
  wire                   wrap     = (cnt_q == LAST);

  // a started high phase always completes, so no runt pulses
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_q   <= '0;
      clk_out <= 1'b0;
    end else if (hold_low) begin
      cnt_q   <= '0;
      clk_out <= 1'b0;
    end else if (wrap) begin
      cnt_q   <= '0;
      clk_out <= !clk_out;
    end else begin
      cnt_q   <= cnt_q + 1'b1;
    end
  end
endmodule : cpm_clk_div

// ---- cpm_pad_model.sv ----
// pad and external logic model for the six configurable pins
`timescale 1ns/1ps
module cpm_pad_model
  import cpm_pkg::*;
(
  input  wire logic                clk_in,
  input  wire logic [CPM_PINS-1:0] pin_out_in,
  input  wire logic [CPM_PINS-1:0] oe_n_in,
  input  wire logic [CPM_PINS-1:0] pu_in,
  input  wire logic [CPM_PINS-1:0] pd_in,
  input  wire logic [CPM_PINS-1:0] ext_en_in,
  input  wire logic [CPM_PINS-1:0] ext_val_in,
  output logic      [CPM_PINS-1:0] pad_out
);
  logic [CPM_PINS-1:0] last_q = '0;

  // device first, then outside driver, then pulls; a bare pad wanders
  always_comb begin
    for (int i = 0; i < CPM_PINS; i++) begin
      if (!oe_n_in[i]) pad_out[i] = pin_out_in[i];
      else if (ext_en_in[i]) pad_out[i] = ext_val_in[i];
      else if (pu_in[i]) pad_out[i] = 1'h1;
      else if (pd_in[i]) pad_out[i] = 1'h0;
      else pad_out[i] = ~last_q[i];
    end
  end

  // remember the level so a floating pad keeps changing
  always @(posedge clk_in) last_q <= pad_out;
endmodule : cpm_pad_model

// ---- cpm_pin_mux_tb.sv ----
// self-checking bench for the configurable pin function mux
`timescale 1ns/1ps
module cpm_pin_mux_tb import cpm_pkg::*;;
  logic                          clk_in = 1'h0;
  logic                          rstn_in = 1'h0;
  logic [CPM_PINS*CPM_SEL_W-1:0] sel = '0;
  logic                          pd_opt = 1'h0, cfgd = 1'h0, susp = 1'h0;
  logic                          chg = 1'h0, wr_n = 1'h1, rd_n = 1'h1;
  logic                          txe_n = 1'h1, rxf_n = 1'h1, sof = 1'h0;
  logic [CPM_GPIO_PINS-1:0]      gd = '0, gdir = '0, gs;
  logic [CPM_PINS-1:0]           ext_en = '0, ext_val = '0, pad;
  logic [CPM_PINS-1:0]           pin, oe_n, pu, pdn;
  logic                          vbus, inh, pwr_n, slp_n;
  int                            bad_count = 0, num_checks = 0;
  int                            cycles = 0, cnt;
  cpm_func_t fn_tab[5] = '{CPM_FN_CHARGER, CPM_FN_WR_STROBE,
    CPM_FN_RD_STROBE, CPM_FN_TX_EMPTY, CPM_FN_RX_FULL};
  int hv[3] = '{CPM_FAST_HALF, CPM_MID_HALF, CPM_SLOW_HALF};

  cpm_pin_mux dut_u (.clk_in(clk_in), .rstn_in(rstn_in),
    .nvm_pin_sel_in(sel), .nvm_suspend_pd_in(pd_opt),
    .usb_configured_in(cfgd), .usb_suspend_in(susp),
    .charger_detect_in(chg), .bitbang_write_strobe_n_in(wr_n),
    .bitbang_read_strobe_n_in(rd_n), .tx_buffer_empty_n_in(txe_n),
    .rx_buffer_full_n_in(rxf_n), .sof_pulse_in(sof), .gpio_data_in(gd),
    .gpio_dir_in(gdir), .cfg_pin_in(pad), .cfg_pin_out(pin),
    .cfg_pin_oe_n_out(oe_n), .pull_up_en_out(pu), .pull_down_en_out(pdn),
    .gpio_sample_out(gs), .vbus_present_out(vbus),
    .suspend_inhibit_out(inh), .power_enable_n_out(pwr_n),
    .sleep_n_out(slp_n));
  cpm_pad_model pad_u (.clk_in(clk_in), .pin_out_in(pin), .oe_n_in(oe_n),
    .pu_in(pu), .pd_in(pdn), .ext_en_in(ext_en), .ext_val_in(ext_val),
    .pad_out(pad));

  // 40 MHz clock
  always #12.5 clk_in = ~clk_in;

  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  // hang guard
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 4000) begin
      bad_count++;
      complete_run();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask : cyc

  task automatic set_pin(input int i, input logic [CPM_SEL_W-1:0] c);
    sel[i*CPM_SEL_W +: CPM_SEL_W] = c;
  endtask : set_pin

  // count rising edges of one pin over n cycles, allow one off unless none expected
  task automatic rises(input int k, input int n, input int e);
    logic p;
    cnt = 0;
    p = pin[k];
    repeat (n) begin
      @(negedge clk_in);
      if (pin[k] === 1'h1 && p === 1'h0) cnt++;
      p = pin[k];
    end
    num_checks++;
    if ((e == 0) ? (cnt != 0) : (cnt > e + 1 || cnt + 1 < e)) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, cnt, e);
    end
  endtask : rises

  initial begin
    cyc(3);
    chk(oe_n, 8'h3f);
    chk({pwr_n, slp_n}, 8'h03);
    cyc(3);
    rstn_in = 1'h1;
    // constant, status and unused selector codes
    set_pin(0, CPM_FN_DRIVE1);
    set_pin(1, CPM_FN_DRIVE0);
    set_pin(3, CPM_FN_POWER_ENABLE_N);
    set_pin(4, CPM_FN_SLEEP);
    set_pin(5, 5'h1f);
    cyc(4);
    chk(oe_n, 8'h24);
    chk(pin & ~oe_n, 8'h19);
    cfgd = 1'h1;
    cyc(4);
    chk(pin & ~oe_n, 8'h11);
    susp = 1'h1;
    cyc(4);
    chk(pin & ~oe_n, 8'h09);
    chk({pwr_n, slp_n}, 8'h02);
    susp = 1'h0;
    cyc(4);
    chk(pin & ~oe_n, 8'h11);
    // pass-through flags on every pin, one source differing at a time
    for (int m = 0; m < 5; m++) begin
      for (int v = 0; v < 2; v++) begin
        {rxf_n, txe_n, rd_n, wr_n, chg} = v ? 5'h1 << m : ~(5'h1 << m);
        sel = {CPM_PINS{fn_tab[m]}};
        cyc(4);
        chk(pin, v ? 8'h3f : 8'h00);
        chk(oe_n, 8'h00);
      end
    end
    // open-drain inverted charger flag
    sel = {CPM_PINS{CPM_FN_CHARGER_N}};
    chg = 1'h1;
    cyc(4);
    chk({oe_n, pin}, 8'h00);
    chg = 1'h0;
    cyc(4);
    chk(oe_n, 8'h3f);
    // gpio: pins 2,3 drive, pins 0,1 sense, pins 4,5 refused
    sel = {CPM_PINS{CPM_FN_GPIO}};
    gdir = 4'hc;
    gd = 4'h4;
    ext_en = 6'h03;
    ext_val = 6'h02;
    cyc(6);
    chk(oe_n, 8'h33);
    chk(pin & ~oe_n, 8'h04);
    chk(pu, 8'h03);
    chk(gs, 8'h06);
    susp = 1'h1;
    pd_opt = 1'h1;
    cyc(4);
    chk({pu, pdn}, 8'h03);
    susp = 1'h0;
    // vbus sense on pin 2, keep-awake on pin 5
    sel = '0;
    set_pin(2, CPM_FN_VBUS);
    set_pin(5, CPM_FN_KEEP_AWAKE);
    ext_en = 6'h24;
    ext_val = 6'h04;
    cyc(6);
    chk({vbus, inh}, 8'h03);
    chk(oe_n, 8'h3f);
    chk(pu, 8'h24);
    ext_val = 6'h20;
    cyc(6);
    chk({vbus, inh}, 8'h00);
    ext_en = '0;
    // timestamp: single then back-to-back frames
    sel = {CPM_PINS{CPM_FN_TSTAMP}};
    cyc(4);
    chk(pin, 8'h00);
    sof = 1'h1;
    cyc(1);
    sof = 1'h0;
    cyc(3);
    chk(pin, 8'h3f);
    sof = 1'h1;
    cyc(2);
    sof = 1'h0;
    cyc(3);
    chk(pin, 8'h3f);
    // divided clocks run, then stop low in suspend
    sel = '0;
    set_pin(0, CPM_FN_CLK_FAST);
    set_pin(1, CPM_FN_CLK_MID);
    set_pin(2, CPM_FN_CLK_SLOW);
    cyc(8);
    for (int k = 0; k < 3; k++) begin
      rises(k, 60, 60 / (2 * hv[k]));
    end
    susp = 1'h1;
    cyc(8);
    for (int k = 0; k < 3; k++) begin
      rises(k, 24, 0);
    end
    chk(pin & 6'h07, 8'h00);
    complete_run();
  end
endmodule : cpm_pin_mux_tb
